/* rtl/ppio_device.sv */
// Device end: two 8-bit ports with ready/strobe handshakes, control byte
// decoder, status register and interrupt lines.
// Assumes host bus signals come from logic on i_mclk; port lines and strobes
// come from peripherals and are synchronised here.
// Notes on behaviour
// - Clear puts both ports in input mode
// - Host sets B bit mode before A bidirectional
// - Bidir A: A handshake inbound, B handshake outbound
// - Mode byte: D1,D0 set, D4/D3 pick port
// - D7:D6 select input, output, bidir, bit
// - Direction byte sets each bit-mode line's direction
// - Condition byte picks logic function raising interrupt
// - Mask byte picks monitored lines for condition
// - Host writes mask right after condition byte
// - Interrupt output gated by per-port enable byte
// - Host follows documented configuration order
// - Status shows pending ports and A's cause
// - Interrupt line low while port requests service
// - Port A read drives input byte to bus
// - Host writes full byte with write code
// - Bit-mode write updates only output lines
// - Input lines ignore written data in bit mode
// - Strobe fall sets request, timing pulse clears
// - Input strobe latches byte, drops ready, requests
// - Bit-mode read returns all lines, latched outputs
`timescale 1ns/10ps
module ppio_device
   import ppio_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Bus and peripheral pins
   ppio_if.device bus
);
   typedef enum logic [2:0] {
      PPIO_EXP_NONE = 3'h0,
      PPIO_EXP_DIR_A = 3'h1,
      PPIO_EXP_DIR_B = 3'h3,
      PPIO_EXP_MASK_A = 3'h2,
      PPIO_EXP_MASK_B = 3'h6
   } ppio_exp_e;

   function automatic logic cond_eval(input ppio_func_e fn,
                                      input logic [7:0] lines,
                                      input logic [7:0] mask);
      logic any_one;
      logic all_one;
      // A set mask bit takes its line out of the evaluation
      any_one = |(lines & ~mask);
      all_one = &(lines | mask);
      case (fn)
         PPIO_FN_AND: cond_eval = all_one;
         PPIO_FN_OR: cond_eval = any_one;
         PPIO_FN_NAND: cond_eval = ~all_one;
         PPIO_FN_NOR: cond_eval = ~any_one;
         default: cond_eval = 1'b0;
      endcase
   endfunction : cond_eval

   function automatic logic [7:0] merge(input logic [7:0] sel,
                                        input logic [7:0] a,
                                        input logic [7:0] b);
      merge = (sel & a) | (~sel & b);
   endfunction : merge

   ppio_mode_e mode [2];
   ppio_func_e func [2];
   ppio_exp_e expect_byte;
   logic [7:0] dir [2];
   logic [7:0] mask [2];
   logic [1:0] ien;
   logic [1:0] cond_on;
   logic [7:0] in_latch [2];
   logic [7:0] out_latch [2];
   logic [1:0] hs_irq;
   logic [1:0] rdy;
   logic [7:0] pin_s1 [2];
   logic [7:0] pin_s2 [2];
   logic [1:0] stb_s1;
   logic [1:0] stb_s2;
   logic [1:0] stb_d;
   logic [1:0] stb_fall;
   logic [1:0] stb_rise;
   logic bidir;
   logic acc;
   logic ctrl_wr;
   logic [1:0] port_rd;
   logic [1:0] port_wr;
   logic [1:0] out_role;
   logic [1:0] tgt;
   logic [1:0] port_irq;
   logic [7:0] wd;

   assign bidir = (mode[0] == PPIO_MODE_BIDIR);
   assign wd = bus.wdata;
   assign acc = bus.cs & bus.host_bus_timing_pulse;
   assign ctrl_wr = acc & ~bus.rd &
                    ({bus.reg_addr_hi, bus.reg_addr_lo} == ADDR_CTRL);
   assign port_rd[0] = acc & bus.rd &
                       ({bus.reg_addr_hi, bus.reg_addr_lo} == ADDR_PORT_A);
   assign port_rd[1] = acc & bus.rd &
                       ({bus.reg_addr_hi, bus.reg_addr_lo} == ADDR_PORT_B);
   assign port_wr[0] = acc & ~bus.rd &
                       ({bus.reg_addr_hi, bus.reg_addr_lo} == ADDR_PORT_A);
   assign port_wr[1] = acc & ~bus.rd &
                       ({bus.reg_addr_hi, bus.reg_addr_lo} == ADDR_PORT_B);
   // Handshake pair 1 serves port A outbound while A is bidirectional
   assign tgt = {~bidir, 1'b0};
   assign out_role[0] = (mode[0] == PPIO_MODE_OUT);
   assign out_role[1] = bidir | (mode[1] == PPIO_MODE_OUT);
   assign stb_fall = stb_d & ~stb_s2;
   assign stb_rise = ~stb_d & stb_s2;
   assign port_irq[0] = hs_irq[0] | (bidir & hs_irq[1]) | cond_on[0];
   assign port_irq[1] = (~bidir & hs_irq[1]) | cond_on[1];

   // Pin and strobe synchronisers
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         pin_s1[0] <= 8'h00;
         pin_s1[1] <= 8'h00;
         pin_s2[0] <= 8'h00;
         pin_s2[1] <= 8'h00;
         stb_s1 <= 2'h3;
         stb_s2 <= 2'h3;
         stb_d <= 2'h3;
      end else begin
         pin_s1[0] <= bus.pa_in;
         pin_s1[1] <= bus.pb_in;
         pin_s2[0] <= pin_s1[0];
         pin_s2[1] <= pin_s1[1];
         stb_s1 <= {bus.strobe_b, bus.strobe_a};
         stb_s2 <= stb_s1;
         stb_d <= stb_s2;
      end
   end

   // Control byte decoder
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         mode[0] <= PPIO_MODE_IN;
         mode[1] <= PPIO_MODE_IN;
         func[0] <= PPIO_FN_AND;
         func[1] <= PPIO_FN_AND;
         dir[0] <= DIR_RESET;
         dir[1] <= DIR_RESET;
         mask[0] <= MASK_RESET;
         mask[1] <= MASK_RESET;
         ien <= 2'h0;
         expect_byte <= PPIO_EXP_NONE;
      end else if (ctrl_wr) begin
         expect_byte <= PPIO_EXP_NONE;
         case (expect_byte)
            PPIO_EXP_DIR_A: dir[0] <= wd;
            PPIO_EXP_DIR_B: dir[1] <= wd;
            PPIO_EXP_MASK_A: mask[0] <= wd;
            PPIO_EXP_MASK_B: mask[1] <= wd;
            default: begin
               if (wd[1:0] == MODE_TAG) begin
                  for (int p = 0; p < 2; p++) begin
                     if (wd[SEL_LSB+1:SEL_LSB] == (p == 0 ? SEL_A : SEL_B))
                     begin
                        mode[p] <=
                           ppio_mode_e'(wd[MODE_LSB+1:MODE_LSB]);
                     end
                  end
                  // Bit mode takes its direction byte next
                  if (wd[MODE_LSB+1:MODE_LSB] == PPIO_MODE_BIT) begin
                     if (wd[SEL_LSB+1:SEL_LSB] == SEL_A) begin
                        expect_byte <= PPIO_EXP_DIR_A;
                     end else if (wd[SEL_LSB+1:SEL_LSB] == SEL_B) begin
                        expect_byte <= PPIO_EXP_DIR_B;
                     end
                  end
               end else if (wd[2:0] == IEN_TAG) begin
                  ien[wd[PORT_BIT]] <= wd[IEN_BIT];
               end else if (wd[2:0] == COND_TAG) begin
                  func[wd[PORT_BIT]] <=
                     ppio_func_e'(wd[FUNC_LSB+1:FUNC_LSB]);
                  if (wd[MASK_NEXT_BIT]) begin
                     expect_byte <= wd[PORT_BIT] ? PPIO_EXP_MASK_B
                                                 : PPIO_EXP_MASK_A;
                  end
               end
            end
         endcase
      end
   end

   // Handshake engine, one per ready/strobe pair
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         hs_irq <= 2'h0;
         rdy <= 2'h3;
         in_latch[0] <= 8'h00;
         in_latch[1] <= 8'h00;
      end else begin
         for (int h = 0; h < 2; h++) begin
            if (mode[tgt[h]] == PPIO_MODE_BIT && !(h == 1 && bidir)) begin
               hs_irq[h] <= 1'b0;
            end else if (out_role[h]) begin
               // Set beats the clear of the same cycle
               if (stb_fall[h]) begin
                  hs_irq[h] <= 1'b1;
               end else if (port_wr[tgt[h]]) begin
                  hs_irq[h] <= 1'b0;
               end
               if (port_wr[tgt[h]]) begin
                  rdy[h] <= 1'b1;
               end else if (stb_rise[h]) begin
                  rdy[h] <= 1'b0;
               end
            end else begin
               if (stb_fall[h]) begin
                  in_latch[tgt[h]] <= pin_s2[tgt[h]];
                  rdy[h] <= 1'b0;
                  hs_irq[h] <= 1'b1;
               end else if (port_rd[tgt[h]]) begin
                  rdy[h] <= 1'b1;
                  hs_irq[h] <= 1'b0;
               end
            end
         end
      end
   end

   // Output latches and bit-mode condition
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         out_latch[0] <= 8'h00;
         out_latch[1] <= 8'h00;
         cond_on <= 2'h0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (port_wr[p]) begin
               if (mode[p] == PPIO_MODE_BIT) begin
                  out_latch[p] <=
                     merge(dir[p], wd, out_latch[p]);
               end else begin
                  out_latch[p] <= wd;
               end
            end
            cond_on[p] <= (mode[p] == PPIO_MODE_BIT) &&
                          cond_eval(func[p], pin_s2[p],
                                    mask[p]);
         end
      end
   end

   // Registered bus and pin outputs
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         bus.rdata <= 8'h00;
         bus.int_a_n <= 1'b1;
         bus.int_b_n <= 1'b1;
         bus.pa_out <= 8'h00;
         bus.pb_out <= 8'h00;
         bus.pa_oe_n <= 8'hff;
         bus.pb_oe_n <= 8'hff;
         bus.rdy_a <= 1'b1;
         bus.rdy_b <= 1'b1;
      end else begin
         case ({bus.reg_addr_hi, bus.reg_addr_lo})
            ADDR_CTRL: bus.rdata <= {4'h0, hs_irq[0], bidir & hs_irq[1],
                                     port_irq[0], port_irq[1]};
            ADDR_PORT_A: bus.rdata <= (mode[0] == PPIO_MODE_BIT)
               ? merge(dir[0], out_latch[0], pin_s2[0])
               : in_latch[0];
            ADDR_PORT_B: bus.rdata <= (mode[1] == PPIO_MODE_BIT)
               ? merge(dir[1], out_latch[1], pin_s2[1])
               : in_latch[1];
            default: bus.rdata <= 8'h00;
         endcase
         bus.int_a_n <= ~(port_irq[0] & ien[0]);
         bus.int_b_n <= ~(port_irq[1] & ien[1]);
         bus.pa_out <= out_latch[0];
         bus.pb_out <= out_latch[1];
         case (mode[0])
            PPIO_MODE_OUT: bus.pa_oe_n <= 8'h00;
            // Drive outbound data only while a byte waits for the peripheral
            PPIO_MODE_BIDIR: bus.pa_oe_n <= {8{~rdy[1]}};
            PPIO_MODE_BIT: bus.pa_oe_n <= ~dir[0];
            default: bus.pa_oe_n <= 8'hff;
         endcase
         case (mode[1])
            PPIO_MODE_OUT: bus.pb_oe_n <= 8'h00;
            PPIO_MODE_BIT: bus.pb_oe_n <= ~dir[1];
            default: bus.pb_oe_n <= 8'hff;
         endcase
         bus.rdy_a <= rdy[0];
         bus.rdy_b <= rdy[1];
      end
   end
endmodule : ppio_device

/* rtl/ppio_host.sv */
// Host end: turns user commands into bus cycles with the timing pulse and
// returns read bytes through a two-entry buffer.
// Assumes the device samples the bus on i_mclk while the pulse is high.
`timescale 1ns/10ps
module ppio_host
   import ppio_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Command port
   input wire logic i_cmd_valid,
   input wire logic i_cmd_read,
   input wire logic [1:0] i_cmd_addr,
   input wire logic [7:0] i_cmd_wdata,
   output logic o_cmd_ready,
   // Read data port
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_data,
   input wire logic i_rsp_ready,
   // Polled interrupt flags, low means pending
   output logic o_host_flag_in_1,
   output logic o_host_flag_in_2,
   // Device bus
   ppio_if.host bus
);
   typedef enum logic [1:0] {
      PPIO_H_IDLE = 2'h0,
      PPIO_H_SETUP = 2'h1,
      PPIO_H_PULSE = 2'h3
   } ppio_hstate_e;

   ppio_hstate_e state;
   ppio_hstate_e next_state;
   logic [7:0] buf_mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic [1:0] next_count;
   logic take;
   logic push;
   logic pop;

   assign take = o_cmd_ready & i_cmd_valid;
   assign push = (state == PPIO_H_PULSE) & bus.rd;
   assign pop = o_rsp_valid & i_rsp_ready;
   assign next_count = count + 2'(push) - 2'(pop);

   always_comb begin
      case (state)
         PPIO_H_IDLE: next_state = take ? PPIO_H_SETUP : PPIO_H_IDLE;
         PPIO_H_SETUP: next_state = PPIO_H_PULSE;
         default: next_state = PPIO_H_IDLE;
      endcase
   end

   // Bus cycle sequencer
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         state <= PPIO_H_IDLE;
         bus.cs <= 1'b0;
         bus.rd <= 1'b1;
         bus.reg_addr_hi <= 1'b0;
         bus.reg_addr_lo <= 1'b0;
         bus.wdata <= 8'h00;
         bus.host_bus_timing_pulse <= 1'b0;
      end else begin
         state <= next_state;
         if (take) begin
            bus.cs <= 1'b1;
            bus.rd <= i_cmd_read;
            bus.reg_addr_hi <= i_cmd_addr[1];
            bus.reg_addr_lo <= i_cmd_addr[0];
            bus.wdata <= i_cmd_wdata;
         end else if (state == PPIO_H_PULSE) begin
            bus.cs <= 1'b0;
         end
         bus.host_bus_timing_pulse <= (next_state == PPIO_H_PULSE);
      end
   end

   // Read buffer; a full buffer holds off new commands
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         o_cmd_ready <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= 8'h00;
         buf_mem[0] <= 8'h00;
         buf_mem[1] <= 8'h00;
      end else begin
         if (push) begin
            buf_mem[wr_ptr] <= bus.rdata;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= next_count;
         o_cmd_ready <= (next_state == PPIO_H_IDLE) && !take &&
                        (next_count != 2'h2);
         o_rsp_valid <= (next_count != 2'h0);
         if (next_count != 2'h0) begin
            if (count == 2'h0 || (count == 2'h1 && pop)) begin
               // Head drains as this read lands, so the bus byte is next
               o_rsp_data <= bus.rdata;
            end else begin
               o_rsp_data <= pop ? buf_mem[~rd_ptr] : buf_mem[rd_ptr];
            end
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         o_host_flag_in_1 <= 1'b1;
         o_host_flag_in_2 <= 1'b1;
      end else begin
         o_host_flag_in_1 <= bus.int_a_n;
         o_host_flag_in_2 <= bus.int_b_n;
      end
   end
endmodule : ppio_host

/* rtl/ppio_if.sv */
// Interface joining the host bus end and the device end, plus the
// peripheral-side pins of the device. Port lines are split into in/out/oe_n.
// Assumes the testbench resolves the port wires and drives the peripherals.
`timescale 1ns/10ps
interface ppio_if;
   logic cs;
   logic reg_addr_hi;
   logic reg_addr_lo;
   logic rd;
   logic host_bus_timing_pulse;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic int_a_n;
   logic int_b_n;
   logic [7:0] pa_in;
   logic [7:0] pa_out;
   logic [7:0] pa_oe_n;
   logic [7:0] pb_in;
   logic [7:0] pb_out;
   logic [7:0] pb_oe_n;
   logic rdy_a;
   logic rdy_b;
   logic strobe_a;
   logic strobe_b;

   modport device (
      input cs, reg_addr_hi, reg_addr_lo, rd, host_bus_timing_pulse, wdata,
      output rdata, int_a_n, int_b_n,
      input pa_in, pb_in, strobe_a, strobe_b,
      output pa_out, pa_oe_n, pb_out, pb_oe_n, rdy_a, rdy_b
   );
   modport host (
      output cs, reg_addr_hi, reg_addr_lo, rd, host_bus_timing_pulse, wdata,
      input rdata, int_a_n, int_b_n
   );
endinterface : ppio_if

/* rtl/ppio_pkg.sv */
// Package for the programmable parallel I/O pair: bus codes, control byte
// fields, port modes and reset values shared by the device and host ends.
// Assumes both ends run on one clock and meet through ppio_if.
package ppio_pkg;
   // Register-address codes {reg_addr_hi, reg_addr_lo}
   localparam logic [1:0] ADDR_CTRL = 2'h1;
   localparam logic [1:0] ADDR_PORT_A = 2'h2;
   localparam logic [1:0] ADDR_PORT_B = 2'h3;
   // Mode-setting byte: D1:D0 = 11, D4:D3 port select, D7:D6 mode
   localparam logic [1:0] MODE_TAG = 2'h3;
   localparam logic [1:0] SEL_A = 2'h1;
   localparam logic [1:0] SEL_B = 2'h2;
   localparam int MODE_LSB = 6;
   localparam int SEL_LSB = 3;
   // Interrupt enable byte: D2:D0 = 001, D3 port, D7 enable
   localparam logic [2:0] IEN_TAG = 3'h1;
   localparam int IEN_BIT = 7;
   // Condition byte: D2:D0 = 100, D3 port, D4 mask follows, D6:D5 function
   localparam logic [2:0] COND_TAG = 3'h4;
   localparam int PORT_BIT = 3;
   localparam int MASK_NEXT_BIT = 4;
   localparam int FUNC_LSB = 5;
   // A set mask bit removes its line; clear leaves every line monitored
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'h00;

   typedef enum logic [1:0] {
      PPIO_MODE_IN = 2'h0,
      PPIO_MODE_OUT = 2'h1,
      PPIO_MODE_BIDIR = 2'h2,
      PPIO_MODE_BIT = 2'h3
   } ppio_mode_e;

   typedef enum logic [1:0] {
      PPIO_FN_AND = 2'h0,
      PPIO_FN_OR = 2'h1,
      PPIO_FN_NAND = 2'h2,
      PPIO_FN_NOR = 2'h3
   } ppio_func_e;
endpackage : ppio_pkg

/* tb/ppio_chk.sv */
// Checker for the bus and port pins between the host and device ends.
// Assumes one clock; port A mode and enable are tracked from control writes.
`timescale 1ns/10ps
module ppio_chk
   import ppio_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Bus signals
   input wire logic cs,
   input wire logic reg_addr_hi,
   input wire logic reg_addr_lo,
   input wire logic rd,
   input wire logic host_bus_timing_pulse,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic int_a_n,
   input wire logic int_b_n,
   // Port signals
   input wire logic [7:0] pa_oe_n,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe_n,
   input wire logic rdy_a,
   input wire logic rdy_b,
   input wire logic strobe_a
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   logic act;
   logic ctl_wr;
   logic b_wr;
   logic skip;
   logic en_a;
   logic bidir_a;
   assign act = cs && host_bus_timing_pulse;
   assign ctl_wr = act && !rd && {reg_addr_hi, reg_addr_lo} == ADDR_CTRL;
   assign b_wr = act && !rd && {reg_addr_hi, reg_addr_lo} == ADDR_PORT_B;
   // Direction and mask bytes can look like mode bytes, so skip them
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         skip <= 1'b0;
      end else if (ctl_wr) begin
         skip <= !skip && ((wdata[1:0] == MODE_TAG && wdata[7:6] == 2'h3)
            || (wdata[2:0] == COND_TAG && wdata[MASK_NEXT_BIT]));
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         en_a <= 1'b0;
      end else if (ctl_wr && !skip && wdata[2:0] == IEN_TAG
            && !wdata[PORT_BIT]) begin
         en_a <= wdata[IEN_BIT];
      end
   end
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         bidir_a <= 1'b0;
      end else if (ctl_wr && !skip && wdata[1:0] == MODE_TAG
            && wdata[4:3] == SEL_A) begin
         bidir_a <= wdata[7:6] == PPIO_MODE_BIDIR;
      end
   end
   reset_idle_a: assert property ($rose(i_reset_n) |->
      pa_oe_n == 8'hff && pb_oe_n == 8'hff && rdy_a && rdy_b && int_a_n)
      else $error("ports not idle after reset");
   pulse_shape_a: assert property ($rose(cs) |=>
      host_bus_timing_pulse ##1 (!host_bus_timing_pulse && !cs))
      else $error("bus cycle shape wrong");
   pulse_cs_a: assert property (host_bus_timing_pulse |-> cs)
      else $error("timing pulse without select");
   null_read_a: assert property (act && rd && !reg_addr_hi
      && !reg_addr_lo |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   mode_out_a: assert property (ctl_wr && !skip && wdata == 8'h53
      |-> ##[1:2] pb_oe_n == 8'h00)
      else $error("output mode not applied");
   strobe_rdy_a: assert property ($fell(strobe_a) && rdy_a
      && pa_oe_n == 8'hff |-> ##[1:5] !rdy_a)
      else $error("input strobe kept ready");
   bit_write_a: assert property (b_wr |-> ##2
      ((pb_out ^ $past(wdata, 2)) & ~pb_oe_n) == 8'h00)
      else $error("output lines not loaded");
   int_gate_a: assert property (!en_a && !$past(en_a) |-> int_a_n)
      else $error("disabled interrupt asserted");
   bidir_dir_a: assert property (bidir_a && $past(bidir_a)
      && $stable(rdy_b) |-> pa_oe_n == {8{~rdy_b}})
      else $error("bidir direction wrong");
   cover property (bidir_a && !rdy_b);
   cover property ($fell(int_b_n));
   cover property (b_wr && pb_oe_n == 8'hf0);
endmodule : ppio_chk

/* tb/ppio_tb_top.sv */
// Testbench joining host and device ends, with peripherals on the pins.
// Assumes the design's contract timing; runs both application sequences.
`timescale 1ns/10ps
module ppio_tb_top
   import ppio_pkg::*;
;
   logic mclk;
   logic reset_n;
   logic cmd_valid;
   logic cmd_read;
   logic [1:0] cmd_addr;
   logic [7:0] cmd_wdata;
   logic cmd_ready;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_ready;
   logic flag_a_n;
   logic flag_b_n;
   logic [7:0] pa_drv;
   logic [7:0] pb_drv;
   logic [7:0] rd_byte;
   int error_cnt;
   int samples_checked;
   int cyc;
   ppio_if bus ();
   // Pins carry the device's value where it drives, the peripheral's else
   assign bus.pa_in = (bus.pa_out & ~bus.pa_oe_n) | (pa_drv & bus.pa_oe_n);
   assign bus.pb_in = (bus.pb_out & ~bus.pb_oe_n) | (pb_drv & bus.pb_oe_n);
   ppio_device i_ppio_device (.i_mclk(mclk), .i_reset_n(reset_n),
      .bus(bus.device));
   ppio_host i_ppio_host (.i_mclk(mclk), .i_reset_n(reset_n),
      .i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read), .i_cmd_addr(cmd_addr),
      .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready),
      .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
      .i_rsp_ready(rsp_ready), .o_host_flag_in_1(flag_a_n),
      .o_host_flag_in_2(flag_b_n), .bus(bus.host));
   ppio_chk i_ppio_chk (.i_mclk(mclk), .i_reset_n(reset_n), .cs(bus.cs),
      .reg_addr_hi(bus.reg_addr_hi), .reg_addr_lo(bus.reg_addr_lo),
      .rd(bus.rd), .host_bus_timing_pulse(bus.host_bus_timing_pulse),
      .wdata(bus.wdata), .rdata(bus.rdata), .int_a_n(bus.int_a_n),
      .int_b_n(bus.int_b_n), .pa_oe_n(bus.pa_oe_n), .pb_out(bus.pb_out),
      .pb_oe_n(bus.pb_oe_n), .rdy_a(bus.rdy_a), .rdy_b(bus.rdy_b),
      .strobe_a(bus.strobe_a));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // Ends one edge after the take so valid is never set twice in a step
   task automatic cmd(input logic r, input logic [1:0] a, input logic [7:0] d);
      cmd_valid <= 1'b1;
      cmd_read <= r;
      cmd_addr <= a;
      cmd_wdata <= d;
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      @(posedge mclk);
   endtask : cmd
   task automatic get_rsp;
      do @(posedge mclk); while (rsp_valid !== 1'b1);
      rd_byte = rsp_data;
   endtask : get_rsp
   task automatic rdc(input logic [1:0] a, input logic [7:0] m,
         input logic [7:0] exp);
      cmd(1'b1, a, 8'h00);
      get_rsp();
      check(rd_byte & m, exp);
   endtask : rdc
   task automatic strobe(input logic b);
      if (b) bus.strobe_b <= 1'b0;
      else bus.strobe_a <= 1'b0;
      tick(3);
      bus.strobe_a <= 1'b1;
      bus.strobe_b <= 1'b1;
      tick(6);
   endtask : strobe
   task automatic do_reset;
      reset_n <= 1'b0;
      tick(3);
      reset_n <= 1'b1;
      tick(2);
   endtask : do_reset

   task automatic reset_values;
      check(8'(bus.rdy_a), 8'h01);
      check(bus.pa_oe_n, 8'hff);
      check(bus.pb_oe_n, 8'hff);
      check(8'(flag_a_n), 8'h01);
      rdc(2'h0, 8'hff, 8'h00);
   endtask : reset_values
   task automatic simple_io;
      cmd(1'b0, ADDR_CTRL, 8'h53);
      tick(3);
      check(bus.pb_oe_n, 8'h00);
      cmd(1'b0, ADDR_CTRL, 8'h81);
      cmd(1'b0, ADDR_CTRL, 8'h89);
      pa_drv <= 8'h5a;
      tick(2);
      strobe(1'b0);
      pa_drv <= 8'hff;
      check(8'(bus.rdy_a), 8'h00);
      check(8'(flag_a_n), 8'h00);
      rdc(ADDR_CTRL, 8'h03, 8'h02);
      rdc(ADDR_PORT_A, 8'hff, 8'h5a);
      tick(3);
      check(8'(bus.rdy_a), 8'h01);
      check(8'(flag_a_n), 8'h01);
      cmd(1'b0, ADDR_PORT_B, 8'hc3);
      tick(3);
      check(bus.pb_out, 8'hc3);
      strobe(1'b1);
      check(8'(bus.rdy_b), 8'h00);
      check(8'(flag_b_n), 8'h00);
      cmd(1'b0, ADDR_PORT_B, 8'h3c);
      tick(4);
      check(8'(flag_b_n), 8'h01);
   endtask : simple_io
   task automatic bit_and_bidir;
      do_reset();
      cmd(1'b0, ADDR_CTRL, 8'hd3);
      cmd(1'b0, ADDR_CTRL, 8'h0f);
      cmd(1'b0, ADDR_CTRL, 8'h7c);
      cmd(1'b0, ADDR_CTRL, 8'h0f);
      cmd(1'b0, ADDR_CTRL, 8'h8b);
      cmd(1'b0, ADDR_CTRL, 8'h81);
      cmd(1'b0, ADDR_CTRL, 8'h89);
      check(bus.pb_oe_n, 8'hf0);
      pb_drv <= 8'h30;
      cmd(1'b0, ADDR_PORT_B, 8'ha5);
      tick(3);
      check(bus.pb_out & 8'h0f, 8'h05);
      rdc(ADDR_PORT_B, 8'hff, 8'h35);
      check(8'(flag_b_n), 8'h01);
      // Output lines hold 5, so only the mask keeps NOR true
      pb_drv <= 8'h00;
      tick(6);
      check(8'(flag_b_n), 8'h00);
      pb_drv <= 8'h10;
      tick(6);
      check(8'(flag_b_n), 8'h01);
      cmd(1'b0, ADDR_PORT_A, 8'h3c);
      tick(3);
      check(bus.pa_out, 8'h3c);
      check(bus.pa_oe_n, 8'h00);
      strobe(1'b1);
      check(bus.pa_oe_n, 8'hff);
      check(8'(flag_a_n), 8'h00);
      rdc(ADDR_CTRL, 8'h06, 8'h06);
      pa_drv <= 8'h96;
      tick(2);
      strobe(1'b0);
      check(8'(bus.rdy_a), 8'h00);
      rdc(ADDR_CTRL, 8'h0a, 8'h0a);
      rdc(ADDR_PORT_A, 8'hff, 8'h96);
      cmd(1'b0, ADDR_CTRL, 8'h01);
      tick(4);
      check(8'(flag_a_n), 8'h01);
      // OR over the monitored upper lines, one of which is high
      cmd(1'b0, ADDR_CTRL, 8'h2c);
      tick(5);
      check(8'(flag_b_n), 8'h00);
   endtask : bit_and_bidir
   // Receiver stalls: two reads fill the buffer and command ready stays low
   task automatic buffer_stall;
      rsp_ready <= 1'b0;
      cmd(1'b1, ADDR_PORT_B, 8'h00);
      cmd(1'b1, 2'h0, 8'h00);
      tick(4);
      check(8'(cmd_ready), 8'h00);
      rsp_ready <= 1'b1;
      get_rsp();
      check(rd_byte, 8'h15);
      get_rsp();
      check(rd_byte, 8'h00);
   endtask : buffer_stall
   task automatic test_done;
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      reset_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_addr = 2'h0;
      cmd_wdata = 8'h00;
      rsp_ready = 1'b1;
      pa_drv = 8'h00;
      pb_drv = 8'h00;
      bus.strobe_a = 1'b1;
      bus.strobe_b = 1'b1;
      error_cnt = 0;
      samples_checked = 0;
      cyc = 0;
      do_reset();
      reset_values();
      simple_io();
      bit_and_bidir();
      buffer_stall();
      test_done();
   end
endmodule : ppio_tb_top
